/* rtl/gtc_core.sv */
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ns
module gtc_core (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  // AHB-Lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic [31:0]      O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // Alternate clock sources
  input  wire logic [3:0]  I_INTERNAL_TRIGGER_IN,
  input  wire logic        I_CHANNEL_PIN_ZERO,
  input  wire logic        I_CHANNEL_PIN_ONE,
  input  wire logic        I_EXT_TRIGGER_INPUT,
  // Status out
  output logic             O_UPDATE_PULSE,
  output logic [15:0]      O_COUNT
);

  // Software-visible state, shadows, divider and bus capture
  logic        counter_run_enable_r;
  logic        update_disable_r;
  logic        dir_r;
  logic [1:0]  center_align_select_r;
  logic [2:0]  slave_mode_select_r;
  logic [2:0]  trigger_source_select_r;
  logic        ext_clock_mode1_enable_r;
  logic        chan_falling_r;
  logic        update_flag_r;
  logic [15:0] prescale_value_r;
  logic [15:0] auto_reload_value_r;
  logic [15:0] prescale_active_r;
  logic [15:0] car_active_r;
  logic [15:0] cnt_r;
  logic [15:0] div_r;
  gtc_pkg::gtc_req_type req_r;
  logic        req_valid_r;

  // Bus write decode
  logic        wr_en;
  logic        soft_update_generate;
  logic [31:0] wd;
  assign wd = I_HWDATA;
  assign wr_en = req_valid_r & req_r.wr;
  assign soft_update_generate = wr_en && req_r.addr == gtc_pkg::SWEVG_OFS && wd[gtc_pkg::SUPD_BIT];

  // Address phase capture
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      req_valid_r <= 1'b0;
      req_r       <= '0;
    end else begin
      req_valid_r <= I_HSEL & I_HREADY & I_HTRANS[1];
      req_r.wr    <= I_HWRITE;
      req_r.addr  <= {I_HADDR[7:2], 2'b00};
    end
  end

  // Slave always ready, always OKAY
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  // Trigger-edge detectors on each source
  logic [3:0] iti_pulse;
  logic       ch0_rise;
  logic       ch0_fall;
  logic       ch1_rise;
  logic       ch1_fall;
  logic       ext_rise;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_iti
      gtc_edge u_iti (
        .i_clk   (I_MCLK),
        .i_rst   (I_RST),
        .i_level (I_INTERNAL_TRIGGER_IN[gi]),
        .o_pulse (iti_pulse[gi])
      );
    end
  endgenerate

  gtc_edge u_ch0r (.i_clk(I_MCLK), .i_rst(I_RST), .i_level(I_CHANNEL_PIN_ZERO), .o_pulse(ch0_rise));
  gtc_edge u_ch0f (.i_clk(I_MCLK), .i_rst(I_RST), .i_level(~I_CHANNEL_PIN_ZERO), .o_pulse(ch0_fall));
  gtc_edge u_ch1r (.i_clk(I_MCLK), .i_rst(I_RST), .i_level(I_CHANNEL_PIN_ONE), .o_pulse(ch1_rise));
  gtc_edge u_ch1f (.i_clk(I_MCLK), .i_rst(I_RST), .i_level(~I_CHANNEL_PIN_ONE), .o_pulse(ch1_fall));
  gtc_edge u_ext (.i_clk(I_MCLK), .i_rst(I_RST), .i_level(I_EXT_TRIGGER_INPUT), .o_pulse(ext_rise));

  // Pulse selected by trigger source code
  function automatic logic trig_pulse(input logic [2:0] sel, input logic [3:0] iti,
                                      input logic c0, input logic c1, input logic ext);
    logic p;
    p = 1'b0;
    case (sel)
      3'h0, 3'h1, 3'h2, 3'h3: p = iti[sel[1:0]];
      3'h4:    p = c0 | c1;
      3'h5:    p = c0;
      3'h6:    p = c1;
      default: p = ext;
    endcase
    return p;
  endfunction

  // Clock source selection
  gtc_pkg::gtc_src_type src;
  logic ch0_edge;
  logic ch1_edge;
  logic timer_tick;
  assign ch0_edge = chan_falling_r ? ch0_fall : ch0_rise;
  assign ch1_edge = chan_falling_r ? ch1_fall : ch1_rise;

  always_comb begin
    if (ext_clock_mode1_enable_r) begin
      src = gtc_pkg::SRC_EXT;
    end else if (slave_mode_select_r == gtc_pkg::SMS_INTERNAL) begin
      src = gtc_pkg::SRC_KERNEL;
    end else if (slave_mode_select_r[2] && slave_mode_select_r != gtc_pkg::SMS_EXTCLK0) begin
      src = gtc_pkg::SRC_KERNEL;
    end else begin
      src = gtc_pkg::SRC_TRIGGER;
    end
  end

  // One prescaler input tick per selected event
  always_comb begin
    case (src)
      gtc_pkg::SRC_KERNEL: timer_tick = 1'b1;
      gtc_pkg::SRC_EXT:    timer_tick = ext_rise;
      default:             timer_tick = trig_pulse(trigger_source_select_r, iti_pulse,
                                                   ch0_edge, ch1_edge, ext_rise);
    endcase
  end

  // Prescaler divide counter
  logic cnt_tick;
  logic center;
  logic ovf_evt;
  logic udf_evt;
  logic upd_evt;
  assign center   = center_align_select_r != 2'b00;
  assign cnt_tick = counter_run_enable_r && timer_tick && div_r == prescale_active_r;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      div_r <= 16'h0000;
    end else if (soft_update_generate && !update_disable_r) begin
      div_r <= 16'h0000;
    end else if (counter_run_enable_r && timer_tick) begin
      div_r <= cnt_tick ? 16'h0000 : div_r + 16'h0001;
    end  // Otherwise holds
  end

  // Overflow and underflow detection on the counter tick
  always_comb begin
    ovf_evt = 1'b0;
    udf_evt = 1'b0;
    if (cnt_tick) begin
      if (center) begin
        ovf_evt = !dir_r && cnt_r == car_active_r - 16'h0001;
        udf_evt = dir_r && cnt_r == 16'h0001;
      end else if (!dir_r) begin
        ovf_evt = cnt_r == car_active_r;
      end else begin
        udf_evt = cnt_r == 16'h0000;
      end
    end
  end
  assign upd_evt = !update_disable_r && (ovf_evt || udf_evt || soft_update_generate);
  assign O_UPDATE_PULSE = upd_evt;

  // Counter
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cnt_r <= gtc_pkg::CNT_RST;
    end else if (soft_update_generate && !update_disable_r) begin
      cnt_r <= (!center && dir_r) ? auto_reload_value_r : 16'h0000;
    end else if (wr_en && req_r.addr == gtc_pkg::CNT_OFS) begin
      cnt_r <= wd[15:0];
    end else if (cnt_tick) begin
      if (center) begin
        cnt_r <= dir_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
      end else if (!dir_r) begin
        cnt_r <= (cnt_r == car_active_r) ? 16'h0000 : cnt_r + 16'h0001;
      end else begin
        cnt_r <= (cnt_r == 16'h0000) ? car_active_r : cnt_r - 16'h0001;
      end
    end  // Otherwise holds
  end
  assign O_COUNT = cnt_r;

  // Direction: software in edge modes, hardware in center mode
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      dir_r <= 1'b0;
    end else if (center) begin
      if (soft_update_generate && !update_disable_r) begin
        dir_r <= 1'b0;  // Restart upward from zero
      end else if (cnt_tick && !dir_r && cnt_r == car_active_r - 16'h0001) begin
        dir_r <= 1'b1;
      end else if (cnt_tick && dir_r && cnt_r == 16'h0001) begin
        dir_r <= 1'b0;
      end
    end else if (wr_en && req_r.addr == gtc_pkg::CTRL0_OFS) begin
      dir_r <= wd[gtc_pkg::DIR_BIT];
    end
  end

  // Shadow registers load on update
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      prescale_active_r <= gtc_pkg::PRE_RST;
      car_active_r      <= gtc_pkg::CAR_RST;
    end else if (upd_evt) begin
      prescale_active_r <= prescale_value_r;
      car_active_r      <= auto_reload_value_r;
    end
  end

  // Update flag: set wins over a software clear
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      update_flag_r <= 1'b0;
    end else if (upd_evt) begin
      update_flag_r <= 1'b1;
    end else if (wr_en && req_r.addr == gtc_pkg::FLAG_OFS && !wd[gtc_pkg::UPF_BIT]) begin
      update_flag_r <= 1'b0;
    end
  end

  // Control and preload register writes
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      counter_run_enable_r     <= 1'b0;
      update_disable_r         <= 1'b0;
      center_align_select_r    <= 2'b00;
      slave_mode_select_r      <= gtc_pkg::SMS_INTERNAL;
      trigger_source_select_r  <= 3'h0;
      ext_clock_mode1_enable_r <= 1'b0;
      chan_falling_r           <= 1'b0;
      prescale_value_r         <= gtc_pkg::PRE_RST;
      auto_reload_value_r      <= gtc_pkg::CAR_RST;
    end else if (wr_en) begin
      if (req_r.addr == gtc_pkg::CTRL0_OFS) begin
        counter_run_enable_r  <= wd[gtc_pkg::RUN_BIT];
        update_disable_r      <= wd[gtc_pkg::NOUPD_BIT];
        center_align_select_r <= wd[gtc_pkg::CAM_LSB +: 2];
      end else if (req_r.addr == gtc_pkg::SMCFG_OFS) begin
        slave_mode_select_r      <= wd[gtc_pkg::SMS_LSB +: 3];
        trigger_source_select_r  <= wd[gtc_pkg::TRG_LSB +: 3];
        ext_clock_mode1_enable_r <= wd[gtc_pkg::EC1_BIT];
        chan_falling_r           <= wd[gtc_pkg::EDGE_BIT];
      end else if (req_r.addr == gtc_pkg::PRE_OFS) begin
        prescale_value_r <= wd[15:0];
      end else if (req_r.addr == gtc_pkg::CAR_OFS) begin
        auto_reload_value_r <= wd[15:0];
      end
    end
  end

  // Read data, registered at the address phase
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (I_HADDR[7:0] == gtc_pkg::CTRL0_OFS) begin
      rd_nxt[gtc_pkg::RUN_BIT]        = counter_run_enable_r;
      rd_nxt[gtc_pkg::NOUPD_BIT]      = update_disable_r;
      rd_nxt[gtc_pkg::DIR_BIT]        = dir_r;
      rd_nxt[gtc_pkg::CAM_LSB +: 2]   = center_align_select_r;
    end else if (I_HADDR[7:0] == gtc_pkg::SMCFG_OFS) begin
      rd_nxt[gtc_pkg::SMS_LSB +: 3]   = slave_mode_select_r;
      rd_nxt[gtc_pkg::TRG_LSB +: 3]   = trigger_source_select_r;
      rd_nxt[gtc_pkg::EC1_BIT]        = ext_clock_mode1_enable_r;
      rd_nxt[gtc_pkg::EDGE_BIT]       = chan_falling_r;
    end else if (I_HADDR[7:0] == gtc_pkg::FLAG_OFS) begin
      rd_nxt[gtc_pkg::UPF_BIT]        = update_flag_r;
    end else if (I_HADDR[7:0] == gtc_pkg::CNT_OFS) begin
      rd_nxt[15:0] = cnt_r;
    end else if (I_HADDR[7:0] == gtc_pkg::PRE_OFS) begin
      rd_nxt[15:0] = prescale_value_r;
    end else if (I_HADDR[7:0] == gtc_pkg::CAR_OFS) begin
      rd_nxt[15:0] = auto_reload_value_r;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_HRDATA <= 32'h0000_0000;
    end else if (I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE) begin
      O_HRDATA <= rd_nxt;
    end
  end

  // Up-mode overflow wraps the counter to zero on the next edge
  up_wrap_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (!center && !dir_r && cnt_tick && cnt_r == car_active_r && !soft_update_generate
     && !(wr_en && req_r.addr == gtc_pkg::CNT_OFS)) |=> cnt_r == 16'h0000)
    else $error("up counter did not wrap");

  // Down-mode underflow reloads
  down_reload_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (!center && dir_r && cnt_tick && cnt_r == 16'h0000 && !soft_update_generate
     && !(wr_en && req_r.addr == gtc_pkg::CNT_OFS)) |=> cnt_r == $past(car_active_r))
    else $error("down counter did not reload");

  // Halted counter holds
  halt_hold_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (!counter_run_enable_r && !wr_en) |=> $stable(cnt_r) && $stable(div_r))
    else $error("halted counter moved");

  // Update disable blocks the pulse and keeps the shadows
  update_disable_block_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    update_disable_r |-> !O_UPDATE_PULSE ##1 ($stable(prescale_active_r) && $stable(car_active_r)))
    else $error("update while disabled");

  // Shadow prescale follows preload after update
  shadow_load_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    upd_evt |=> prescale_active_r == $past(prescale_value_r) && car_active_r == $past(auto_reload_value_r))
    else $error("shadow not loaded");

  // Flag set by update
  flag_set_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    upd_evt |=> update_flag_r)
    else $error("flag not set");

  // Soft update in up mode clears counter
  soft_clear_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (soft_update_generate && !update_disable_r && !(dir_r && !center)) |=> cnt_r == 16'h0000)
    else $error("soft update did not clear");

  // Divider never passes the active prescale
  div_bound_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (counter_run_enable_r && timer_tick && div_r == prescale_active_r && !soft_update_generate)
    |=> div_r == 16'h0000)
    else $error("divider did not wrap");

  // Center mode rising tick at the top, with no soft update in the way
  sequence rise_top_s;
    center && cnt_tick && !dir_r && cnt_r == car_active_r - 16'h0001
    && !(soft_update_generate && !update_disable_r);
  endsequence

  // Center mode turns downward after the overflow tick
  center_turn_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
    rise_top_s |=> dir_r)
    else $error("center counter did not turn");

endmodule

/* rtl/gtc_edge.sv */
`timescale 1ns/1ns
// Rising-edge detector producing a single-cycle pulse
module gtc_edge (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Level in, pulse out
  input  wire logic i_level,
  output logic      o_pulse
);
  logic prev_r;

  // Previous level
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_r <= i_level;  // Track the line so no false edge follows reset
    end else begin
      prev_r <= i_level;
    end
  end

  assign o_pulse = i_level & ~prev_r & ~i_rst;
endmodule

/* rtl/gtc_pkg.sv */
package gtc_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL0_OFS  = 8'h00;  // control_reg_zero
  localparam logic [7:0] CTRL1_OFS  = 8'h04;  // control_reg_one
  localparam logic [7:0] SMCFG_OFS  = 8'h08;  // slave_mode_config_reg
  localparam logic [7:0] FLAG_OFS   = 8'h10;  // interrupt_flag_reg
  localparam logic [7:0] SWEVG_OFS  = 8'h14;  // soft_event_gen_reg
  localparam logic [7:0] CNT_OFS    = 8'h24;
  localparam logic [7:0] PRE_OFS    = 8'h28;  // prescale_reg
  localparam logic [7:0] CAR_OFS    = 8'h2c;  // reload_reg

  // Field positions
  localparam int RUN_BIT    = 0;
  localparam int NOUPD_BIT  = 1;
  localparam int DIR_BIT    = 4;
  localparam int CAM_LSB    = 5;
  localparam int SMS_LSB    = 0;
  localparam int TRG_LSB    = 4;
  localparam int EC1_BIT    = 14;
  localparam int UPF_BIT    = 0;
  localparam int SUPD_BIT   = 0;
  localparam int EDGE_BIT   = 8;

  // Reset values
  localparam logic [15:0] CAR_RST = 16'hffff;
  localparam logic [15:0] PRE_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // Slave mode and trigger codes
  localparam logic [2:0] SMS_INTERNAL = 3'h0;
  localparam logic [2:0] SMS_EXTCLK0  = 3'h7;
  localparam logic [2:0] TRG_EXT      = 3'h7;

  // Source chosen for the prescaler input
  typedef enum {SRC_KERNEL, SRC_TRIGGER, SRC_EXT} gtc_src_type;

  // Bus request carrier
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
  } gtc_req_type;

endpackage

/* tb/gtc_src_model.sv */
`timescale 1ns/1ns
// Stands in for other timers and pins; every line rests low between bursts
module gtc_src_model (
  // Clock
  input  wire logic i_clk,
  // Source levels
  output logic [3:0] o_trig,
  output logic       o_ch0,
  output logic       o_ch1,
  output logic       o_ext
);
  logic [6:0] lines_r;

  // Map the source lines onto the outputs
  assign o_trig = lines_r[3:0];
  assign o_ch0  = lines_r[4];
  assign o_ch1  = lines_r[5];
  assign o_ext  = lines_r[6];

  // Idle level at time zero
  initial lines_r = 7'h00;

  // Full pulses on one line: three cycles high, three low
  task automatic pulses(input int sel, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      lines_r[sel] <= 1'b1;
      repeat (3) @(posedge i_clk);
      lines_r[sel] <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [3:0]  trig;
  logic        ch0;
  logic        ch1;
  logic        ext_trig;
  logic        upd;
  logic [15:0] cnt;
  logic [31:0] rd;
  logic [15:0] v;
  int          c;
  int          mismatches;
  int          num_checks;
  // Register reset table and clock source table
  logic [7:0]  ro_t [6] = '{8'h00, 8'h28, 8'h2c, 8'h08, 8'h24, 8'h40};
  logic [31:0] re_t [6] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0};
  logic [15:0] cfg_t [11] = '{16'h0007, 16'h0017, 16'h0027, 16'h0037, 16'h0057,
                              16'h0067, 16'h0077, 16'h4000, 16'h0157, 16'h0041, 16'h0063};
  int          sel_t [11] = '{0, 1, 2, 3, 4, 5, 6, 6, 4, 4, 5};

  gtc_core i_gtc_core (
    .I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_INTERNAL_TRIGGER_IN(trig), .I_CHANNEL_PIN_ZERO(ch0), .I_CHANNEL_PIN_ONE(ch1),
    .I_EXT_TRIGGER_INPUT(ext_trig), .O_UPDATE_PULSE(upd), .O_COUNT(cnt)
  );

  gtc_src_model i_gtc_src_model (.i_clk(clk), .o_trig(trig), .o_ch0(ch0), .o_ch1(ch1), .o_ext(ext_trig));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fail_now();
    mismatches++;
    complete_run();
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) fail_now();
    rd = hrdata;
  endtask

  // Cycles to the next update pulse, in c
  task automatic wait_upd();
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (upd !== 1'b1 && c < 200);
    if (upd !== 1'b1) fail_now();
  endtask

  // Update pulses seen over n cycles, in c
  task automatic count_upd(input int n);
    c = 0;
    repeat (n) begin
      @(posedge clk);
      if (upd === 1'b1) c++;
    end
  endtask

  task automatic reset_values();
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ro_t[k], 32'h0);
      check(rd, re_t[k]);
    end
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic up_count();
    bus(1'b1, gtc_pkg::CAR_OFS, 32'h3);
    bus(1'b1, gtc_pkg::CNT_OFS, 32'h2);
    bus(1'b1, gtc_pkg::SWEVG_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check({16'h0, cnt}, 32'h0);
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h1);
    wait_upd();
    wait_upd();
    check(c, 4);
  endtask

  task automatic hold_stopped();
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h0);
    @(posedge clk);
    v = cnt;
    count_upd(30);
    check(c, 0);
    check({16'h0, cnt}, {16'h0, v});
  endtask

  task automatic prescale_change();
    bus(1'b1, gtc_pkg::PRE_OFS, 32'h2);
    bus(1'b1, gtc_pkg::CAR_OFS, 32'h5);
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h1);
    wait_upd();
    check({31'h0, c <= 5}, 32'h1);
    wait_upd();
    check(c, 18);
  endtask

  task automatic down_count();
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h10);
    bus(1'b1, gtc_pkg::SWEVG_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check({16'h0, cnt}, 32'h5);
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h11);
    wait_upd();
    wait_upd();
    check(c, 18);
  endtask

  task automatic center_count();
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h20);
    bus(1'b1, gtc_pkg::CAR_OFS, 32'hc);
    bus(1'b1, gtc_pkg::SWEVG_OFS, 32'h1);
    repeat (2) @(posedge clk);
    check({16'h0, cnt}, 32'h0);
    bus(1'b1, gtc_pkg::FLAG_OFS, 32'h0);
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h21);
    wait_upd();
    v = cnt;
    bus(1'b0, gtc_pkg::CTRL0_OFS, 32'h0);
    check({31'h0, rd[4]}, 32'h1);
    bus(1'b0, gtc_pkg::FLAG_OFS, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
    bus(1'b1, gtc_pkg::FLAG_OFS, 32'h0);
    wait_upd();
    check({31'h0, cnt < v}, 32'h1);
    bus(1'b0, gtc_pkg::FLAG_OFS, 32'h0);
    check({31'h0, rd[0]}, 32'h1);
  endtask

  task automatic update_off();
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h3);
    count_upd(200);
    check(c, 0);
  endtask

  task automatic clock_sources();
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h0);
    bus(1'b1, gtc_pkg::PRE_OFS, 32'h0);
    bus(1'b1, gtc_pkg::CAR_OFS, 32'hffff);
    for (int k = 0; k < 11; k++) begin
      bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h0);
      bus(1'b1, gtc_pkg::SMCFG_OFS, {16'h0, cfg_t[k]});
      bus(1'b1, gtc_pkg::SWEVG_OFS, 32'h1);
      bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h1);
      i_gtc_src_model.pulses(sel_t[k], 3);
      repeat (3) @(posedge clk);
      check({16'h0, cnt}, 32'h3);
    end
    bus(1'b1, gtc_pkg::SMCFG_OFS, 32'h4);
    bus(1'b1, gtc_pkg::SWEVG_OFS, 32'h1);
    bus(1'b1, gtc_pkg::CTRL0_OFS, 32'h1);
    repeat (10) @(posedge clk);
    check({31'h0, cnt >= 16'h8}, 32'h1);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    reset_values();
    up_count();
    hold_stopped();
    prescale_change();
    down_count();
    center_count();
    update_off();
    clock_sources();
    complete_run();
  end
endmodule
